// file: core/oms_selector.sv
// Operation-mode selection package and interlock selector
//
// Function
// [RL1] With mode select 7 and the interlock off, external mode is forced and panel or remote-link changes refused.
// [RL2] The interlock comes from the input terminal whose function code is 12.
// [RL3] With no terminal coded 12, the output-stop input serves as interlock while mode select is 7.
// [RL4] Interlock on allows switching among modes, stops the output in external mode, and gates writes by write select.
// [RL5] Interlock off rejects writes to every parameter but the mode select.
// [RL6] The forced change to external mode ignores the start inputs, so a held start runs on external commands.
// [RL7] In external mode the interlock on stops the output and off resumes it, with panel and link changes barred.
// [RL8] With the interlock on, a change to panel mode is refused while a start input is on.
// [RL9] Leaving mode select 7 gives the output-stop input back its stop role, and setting 7 makes it interlock at once.
// [RL10] As interlock, the output-stop input follows the stop logic parameter, where 2 inverts it.
// [RL11] The panel/external switch acts only when stopped with start off, for mode select 0, 6 or 7, and 6 also while running.
// [RL12] The panel/external switch comes from the terminal whose function code is 16.
// [RL13] For 0, 6 and 7 with interlock on, that switch on selects external and off selects panel, 6 keeping the run.
// [RL14] Mode select 1 fixes panel, 2 fixes external but allows remote link, 3 and 4 fix combined mode.
// [RL15] Precedence is mode select, interlock, external/remote switch, panel/remote switch, panel/external switch, start-up; start-up setting is not used.
// [RL16] After an alarm following a forced change, the stop/reset key resets the drive.
// [RL17] Inputs are sampled in the control clock and every mode decision lands on one edge.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
package oms_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CODE_W = 7;
  // Register byte addresses
  localparam logic [7:0] A_MODE_SEL = 8'h00;
  localparam logic [7:0] A_STOP_LOGIC = 8'h04;
  localparam logic [7:0] A_WRITE_SEL = 8'h08;
  localparam logic [7:0] A_STARTUP = 8'h0C;
  localparam logic [7:0] A_MODE_REQ = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_TERM_BASE = 8'h20;
  // Mode request bits
  localparam int REQ_PANEL_BIT = 0;
  localparam int REQ_EXT_BIT = 1;
  localparam int REQ_LINK_BIT = 2;
  // Status bit positions
  localparam int ST_MODE_LSB = 0;
  localparam int ST_STOP_BIT = 2;
  localparam int ST_IL_BIT = 3;
  localparam int ST_WREN_BIT = 4;
  localparam int ST_FORCED_BIT = 5;
  // Parameter values
  localparam logic [3:0] MS_NORMAL = 4'h0;
  localparam logic [3:0] MS_PANEL = 4'h1;
  localparam logic [3:0] MS_EXT = 4'h2;
  localparam logic [3:0] MS_COMB1 = 4'h3;
  localparam logic [3:0] MS_COMB2 = 4'h4;
  localparam logic [3:0] MS_SWITCH = 4'h6;
  localparam logic [3:0] MS_INTERLOCK = 4'h7;
  localparam logic [1:0] SL_INVERT = 2'h2;
  localparam logic [1:0] WS_BLOCK = 2'h1;
  localparam logic [CODE_W-1:0] FC_INTERLOCK = 7'h0C;
  localparam logic [CODE_W-1:0] FC_PANEL_EXT = 7'h10;
  localparam logic [CODE_W-1:0] FC_PANEL_LINK = 7'h41;
  localparam logic [CODE_W-1:0] FC_EXT_LINK = 7'h42;
  // Reset values
  localparam logic [3:0] RST_MODE_SEL = 4'h0;
  localparam logic [1:0] RST_STOP_LOGIC = 2'h0;
  localparam logic [1:0] RST_WRITE_SEL = 2'h0;
  localparam logic [1:0] RST_STARTUP = 2'h0;
  localparam logic [CODE_W-1:0] RST_TERM_FN = 7'h00;
  typedef enum logic [1:0] {mode_ext, mode_panel, mode_link, mode_comb} oms_mode_t;
endpackage

`timescale 1ns/10ps
`default_nettype none
module oms_selector #(
  parameter int N_TERM = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [oms_pkg::ADDR_W-1:0] addr,
  input wire logic [oms_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [oms_pkg::DATA_W-1:0] rdata,
  // Terminal pins
  input wire logic [N_TERM-1:0] term_in,
  input wire logic output_stop_input,
  input wire logic forward_start_input,
  input wire logic reverse_start_input,
  // Drive and panel status, same clock
  input wire logic running,
  input wire logic alarm,
  input wire logic stop_reset_key,
  // Results
  output logic [1:0] op_mode,
  output logic output_stop,
  output logic param_write_en,
  output logic drive_reset
);
  localparam int IW = $clog2(N_TERM);
  localparam int AW = oms_pkg::ADDR_W;

  logic [N_TERM-1:0] term_s;
  logic stop_s, fwd_s, rev_s;
  logic [3:0] mode_sel_q;
  logic [1:0] stop_logic_q, write_sel_q, startup_q;
  logic [N_TERM-1:0][oms_pkg::CODE_W-1:0] term_fn_q;
  logic [oms_pkg::DATA_W-1:0] rdata_q;
  oms_pkg::oms_mode_t op_mode_q, mode_d;
  logic output_stop_q, forced_q, drive_reset_q, forced_evt;

  // Pins cross into the control clock first
  oms_sync #(.W(N_TERM + 3)) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({term_in, output_stop_input, forward_start_input, reverse_start_input}),
    .sync_out({term_s, stop_s, fwd_s, rev_s})
  ); // see [RL17]

  // Finds the terminal carrying a function code: {hit, index}
  function automatic logic [IW:0] find_code(input logic [N_TERM-1:0][oms_pkg::CODE_W-1:0] fn,
                                            input logic [oms_pkg::CODE_W-1:0] code);
    logic [IW:0] r;
    r = '0;
    for (int i = N_TERM - 1; i >= 0; i--)
    begin
      if (fn[i] == code)
      begin
        r = {1'b1, IW'(i)};
      end
    end
    return r;
  endfunction

  wire [IW:0] f_il = find_code(term_fn_q, oms_pkg::FC_INTERLOCK); // see [RL2]
  wire [IW:0] f_pe = find_code(term_fn_q, oms_pkg::FC_PANEL_EXT); // see [RL12]
  wire [IW:0] f_pl = find_code(term_fn_q, oms_pkg::FC_PANEL_LINK);
  wire [IW:0] f_el = find_code(term_fn_q, oms_pkg::FC_EXT_LINK);
  wire pe_on = term_s[f_pe[IW-1:0]];
  wire pl_on = term_s[f_pl[IW-1:0]];
  wire el_on = term_s[f_el[IW-1:0]];

  wire il_mode = (mode_sel_q == oms_pkg::MS_INTERLOCK);
  // Output-stop input as interlock only while no terminal holds the code
  wire stop_is_il = il_mode && !f_il[IW]; // see [RL3] [RL9]
  wire stop_level = (stop_logic_q == oms_pkg::SL_INVERT) ? !stop_s : stop_s; // see [RL10]
  wire il_level = f_il[IW] ? term_s[f_il[IW-1:0]] : stop_level;
  wire il_on = !il_mode || il_level;
  wire start_on = fwd_s || rev_s;
  wire stopped = !running && !start_on;
  wire can_sw = stopped || (mode_sel_q == oms_pkg::MS_SWITCH); // see [RL11]

  // Register port decode
  wire hit_mode = (addr == oms_pkg::A_MODE_SEL);
  wire hit_wsel = (addr == oms_pkg::A_WRITE_SEL);
  wire in_term = (addr >= oms_pkg::A_TERM_BASE) && (addr < oms_pkg::A_TERM_BASE + AW'(4 * N_TERM));
  wire [AW-1:0] term_off = addr - oms_pkg::A_TERM_BASE;
  wire [IW-1:0] term_idx = term_off[IW+1:2];
  // Only the mode select stays writable without the interlock
  wire wr_en_others = il_on && (write_sel_q != oms_pkg::WS_BLOCK); // see [RL4] [RL5]
  wire wr_ok = wr && (hit_mode || (hit_wsel && il_on) || wr_en_others);
  wire req_wr = wr && (addr == oms_pkg::A_MODE_REQ);
  wire req_panel = req_wr && wdata[oms_pkg::REQ_PANEL_BIT];
  wire req_ext = req_wr && wdata[oms_pkg::REQ_EXT_BIT];
  wire req_link = req_wr && wdata[oms_pkg::REQ_LINK_BIT];
  // Panel refused with a start on while the interlock allows switching
  wire panel_ok = !(il_mode && start_on); // see [RL8]
  wire oms_pkg::oms_mode_t pick_pe = (f_pe[IW] && pe_on) ? oms_pkg::mode_ext : oms_pkg::mode_panel;

  // Mode arbitration, highest precedence first
  always_comb
  begin
    mode_d = op_mode_q;
    forced_evt = 1'b0;
    case (mode_sel_q) // see [RL15]
      oms_pkg::MS_PANEL: mode_d = oms_pkg::mode_panel; // see [RL14]
      oms_pkg::MS_EXT:
      begin
        // A link request sticks until an external request or the terminal takes it back
        if (req_link || (f_el[IW] && el_on))
        begin
          mode_d = oms_pkg::mode_link;
        end
        else if (req_ext || f_el[IW] || (op_mode_q != oms_pkg::mode_link))
        begin
          mode_d = oms_pkg::mode_ext; // see [RL14]
        end
      end
      oms_pkg::MS_COMB1, oms_pkg::MS_COMB2: mode_d = oms_pkg::mode_comb; // see [RL14]
      oms_pkg::MS_NORMAL, oms_pkg::MS_SWITCH, oms_pkg::MS_INTERLOCK:
      begin
        if (il_mode && !il_level)
        begin
          // Start inputs deliberately not consulted here
          mode_d = oms_pkg::mode_ext; // see [RL1] [RL6]
          forced_evt = (op_mode_q != oms_pkg::mode_ext);
        end
        else if (can_sw)
        begin
          if (f_el[IW] && el_on)
          begin
            mode_d = oms_pkg::mode_link;
          end
          else if (f_pl[IW])
          begin
            mode_d = pl_on ? pick_pe : oms_pkg::mode_link;
          end
          else if (f_el[IW])
          begin
            mode_d = oms_pkg::mode_ext;
          end
          else if (f_pe[IW])
          begin
            mode_d = pick_pe; // see [RL13]
          end
          else if (req_panel && panel_ok)
          begin
            mode_d = oms_pkg::mode_panel;
          end
          else if (req_ext)
          begin
            mode_d = oms_pkg::mode_ext;
          end
          else if (req_link)
          begin
            mode_d = oms_pkg::mode_link;
          end
        end
      end
      default: mode_d = op_mode_q;
    endcase
  end

  // Interlock on stops external running whichever input carries it; a free stop pin keeps its stop role
  wire stop_d = (il_mode && il_level && mode_d == oms_pkg::mode_ext)
                || (!stop_is_il && stop_level); // see [RL4] [RL7] [RL9]

  wire [oms_pkg::DATA_W-1:0] status_w = {26'h0, forced_q, wr_en_others, il_on, output_stop_q, op_mode_q};
  wire [oms_pkg::DATA_W-1:0] rd_val =
    hit_mode ? {28'h0, mode_sel_q} :
    (addr == oms_pkg::A_STOP_LOGIC) ? {30'h0, stop_logic_q} :
    hit_wsel ? {30'h0, write_sel_q} :
    (addr == oms_pkg::A_STARTUP) ? {30'h0, startup_q} :
    (addr == oms_pkg::A_STATUS) ? status_w :
    in_term ? {25'h0, term_fn_q[term_idx]} : 32'h0;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mode_sel_q <= oms_pkg::RST_MODE_SEL;
      stop_logic_q <= oms_pkg::RST_STOP_LOGIC;
      write_sel_q <= oms_pkg::RST_WRITE_SEL;
      startup_q <= oms_pkg::RST_STARTUP;
      term_fn_q <= {N_TERM{oms_pkg::RST_TERM_FN}};
    end
    else if (wr_ok)
    begin
      if (hit_mode)
        mode_sel_q <= wdata[3:0];
      if (addr == oms_pkg::A_STOP_LOGIC)
        stop_logic_q <= wdata[1:0];
      if (hit_wsel)
        write_sel_q <= wdata[1:0];
      if (addr == oms_pkg::A_STARTUP)
        startup_q <= wdata[1:0];
      if (in_term)
        term_fn_q[term_idx] <= wdata[oms_pkg::CODE_W-1:0];
    end
  end

  // Mode, stop and reset all settle on one edge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      op_mode_q <= oms_pkg::mode_ext;
      output_stop_q <= 1'b0;
      forced_q <= 1'b0;
      drive_reset_q <= 1'b0;
      rdata_q <= 32'h0;
    end
    else
    begin
      op_mode_q <= mode_d; // see [RL17]
      output_stop_q <= stop_d;
      forced_q <= forced_evt || (forced_q && !drive_reset_q);
      drive_reset_q <= stop_reset_key && alarm && forced_q; // see [RL16]
      rdata_q <= rd ? rd_val : 32'h0;
    end
  end

  assign rdata = rdata_q;
  assign op_mode = op_mode_q;
  assign output_stop = output_stop_q;
  assign param_write_en = wr_en_others;
  assign drive_reset = drive_reset_q;

  a_forced_ext: assert property (@(posedge clk) disable iff (rst) // see [RL1]
    (il_mode && !il_level) |=> (op_mode_q == oms_pkg::mode_ext))
    else $error("interlock off did not force external mode");
  a_write_reject: assert property (@(posedge clk) disable iff (rst) // see [RL5]
    (wr && addr == oms_pkg::A_STOP_LOGIC && il_mode && !il_level) |=> $stable(stop_logic_q))
    else $error("write accepted with interlock off");
  a_stop_polarity: assert property (@(posedge clk) disable iff (rst) // see [RL10]
    (il_mode && !f_il[IW] && (stop_s == (stop_logic_q == oms_pkg::SL_INVERT))) |=> (op_mode_q == oms_pkg::mode_ext))
    else $error("output-stop input polarity wrong as interlock");
  a_ext_stop: assert property (@(posedge clk) disable iff (rst) // see [RL7]
    (il_mode && il_level && mode_d == oms_pkg::mode_ext) |=> output_stop_q)
    else $error("output not stopped in external mode with interlock on");
  a_stop_role: assert property (@(posedge clk) disable iff (rst) // see [RL9]
    (!il_mode && stop_level) |=> output_stop_q)
    else $error("output-stop role not restored");
  a_panel_fixed: assert property (@(posedge clk) disable iff (rst) // see [RL14]
    (mode_sel_q == oms_pkg::MS_PANEL) |=> (op_mode_q == oms_pkg::mode_panel))
    else $error("mode select 1 did not fix panel mode");
  a_comb_fixed: assert property (@(posedge clk) disable iff (rst) // see [RL14]
    (mode_sel_q == oms_pkg::MS_COMB1 || mode_sel_q == oms_pkg::MS_COMB2) |=> (op_mode_q == oms_pkg::mode_comb))
    else $error("combined mode not fixed");
  a_panel_start: assert property (@(posedge clk) disable iff (rst) // see [RL8]
    (il_mode && il_level && start_on && op_mode_q != oms_pkg::mode_panel && !f_pe[IW] && !f_pl[IW] && !f_el[IW])
    |=> (op_mode_q != oms_pkg::mode_panel))
    else $error("panel mode taken with a start input on");
  a_switch_run: assert property (@(posedge clk) disable iff (rst) // see [RL11]
    (mode_sel_q == oms_pkg::MS_NORMAL && !stopped && !req_wr) |=> $stable(op_mode_q))
    else $error("mode changed while running");
  a_key_reset: assert property (@(posedge clk) disable iff (rst) // see [RL16]
    (stop_reset_key && alarm && forced_q) |=> drive_reset_q ##1 !forced_q)
    else $error("stop/reset key did not reset after forced change");
endmodule
`default_nettype wire

// file: core/oms_sync.sv
// Two-stage synchroniser for asynchronous terminal inputs
`timescale 1ns/10ps
`default_nettype none
module oms_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin side and synchronised side
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // The first stage feeds the second stage only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire

// file: verification/oms_term_model.sv
// Model of the control terminals and operation panel facing the selector
`timescale 1ns/10ps
`default_nettype none
module oms_term_model (
  // Clock
  input wire logic clk,
  // Commanded levels: [6:0] terminals, 7 stop, 8 fwd, 9 rev, 10 run, 11 alarm, 12 key
  input wire logic [12:0] cmd,
  // Pins toward the selector
  output logic [6:0] term_in,
  output logic output_stop_input,
  output logic forward_start_input,
  output logic reverse_start_input,
  output logic running,
  output logic alarm,
  output logic stop_reset_key
);
  // Contacts move only just after an edge, so no pin changes near sampling
  initial
  begin
    {stop_reset_key, alarm, running, reverse_start_input} = 4'h0;
    {forward_start_input, output_stop_input, term_in} = 9'h000;
  end
  always @(posedge clk)
  begin
    {stop_reset_key, alarm, running, reverse_start_input} <= cmd[12:9];
    {forward_start_input, output_stop_input, term_in} <= cmd[8:0];
  end
endmodule
`default_nettype wire

// file: verification/tb_oms_selector.sv
// Self-checking bench for the interlock selector
`timescale 1ns/10ps
`default_nettype none
module tb_oms_selector;
  localparam logic [1:0] EXT = oms_pkg::mode_ext;
  localparam logic [1:0] PNL = oms_pkg::mode_panel;
  localparam logic [1:0] LINK = oms_pkg::mode_link;
  localparam logic [1:0] COMB = oms_pkg::mode_comb;
  localparam logic [7:0] MS = oms_pkg::A_MODE_SEL;
  localparam logic [7:0] SL = oms_pkg::A_STOP_LOGIC;
  localparam logic [7:0] WS = oms_pkg::A_WRITE_SEL;
  localparam logic [7:0] RQ = oms_pkg::A_MODE_REQ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [12:0] pins = 13'h0;
  logic [6:0] term_in;
  logic output_stop_input, forward_start_input, reverse_start_input, running, alarm, stop_reset_key;
  logic [1:0] op_mode;
  logic output_stop, param_write_en, drive_reset;
  logic got;
  int fail_count = 0;
  int checks = 0;

  always #4 clk = ~clk;

  oms_term_model i_oms_term_model (.clk(clk), .cmd(pins), .term_in(term_in),
    .output_stop_input(output_stop_input), .forward_start_input(forward_start_input),
    .reverse_start_input(reverse_start_input), .running(running), .alarm(alarm),
    .stop_reset_key(stop_reset_key));

  oms_selector i_oms_selector (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .term_in(term_in), .output_stop_input(output_stop_input),
    .forward_start_input(forward_start_input), .reverse_start_input(reverse_start_input),
    .running(running), .alarm(alarm), .stop_reset_key(stop_reset_key), .op_mode(op_mode),
    .output_stop(output_stop), .param_write_en(param_write_en), .drive_reset(drive_reset));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic r(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), rdata, exp);
  endtask

  task automatic pin(input int b, input logic v);
    @(posedge clk);
    pins[b] <= v;
  endtask

  // Pins need four edges through the model to reach the outputs, so five leaves margin
  task automatic st(input logic [1:0] m, input logic os, input logic we);
    repeat (5) @(posedge clk);
    #1;
    chk("op_mode", 32'(op_mode), 32'(m));
    chk("output_stop", 32'(output_stop), 32'(os));
    chk("param_write_en", 32'(param_write_en), 32'(we));
  endtask

  task automatic wrap_up;
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    wrap_up;
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    st(EXT, 1'b0, 1'b1);
    r(8'h3C, 32'h0);
    r(RQ, 32'h0);
    w(MS, 32'h1);
    st(PNL, 1'b0, 1'b1);
    w(MS, 32'h2);
    st(EXT, 1'b0, 1'b1);
    w(RQ, 32'h4);
    st(LINK, 1'b0, 1'b1);
    w(RQ, 32'h2);
    st(EXT, 1'b0, 1'b1);
    // External/link switch on terminal 2
    w(8'h28, 32'h42);
    pin(2, 1'b1);
    st(LINK, 1'b0, 1'b1);
    pin(2, 1'b0);
    st(EXT, 1'b0, 1'b1);
    w(8'h28, 32'h0);
    w(MS, 32'h3);
    st(COMB, 1'b0, 1'b1);
    w(MS, 32'h4);
    st(COMB, 1'b0, 1'b1);
    w(MS, 32'h0);
    w(8'h24, 32'h10);
    pin(1, 1'b1);
    st(EXT, 1'b0, 1'b1);
    pin(1, 1'b0);
    st(PNL, 1'b0, 1'b1);
    pin(10, 1'b1);
    pin(1, 1'b1);
    st(PNL, 1'b0, 1'b1);
    w(MS, 32'h6);
    st(EXT, 1'b0, 1'b1);
    pin(10, 1'b0);
    pin(1, 1'b0);
    st(PNL, 1'b0, 1'b1);
    // Panel/link switch on terminal 2 outranks the panel/external one
    w(8'h28, 32'h41);
    st(LINK, 1'b0, 1'b1);
    pin(2, 1'b1);
    st(PNL, 1'b0, 1'b1);
    w(8'h28, 32'h0);
    pin(2, 1'b0);
    st(PNL, 1'b0, 1'b1);
    w(8'h24, 32'h0);
    // Interlock taken from the stop pin, which is low, so the forced change fires
    w(MS, 32'h7);
    st(EXT, 1'b0, 1'b0);
    w(SL, 32'h2);
    r(SL, 32'h0);
    r(MS, 32'h7);
    w(RQ, 32'h1);
    st(EXT, 1'b0, 1'b0);
    pin(11, 1'b1);
    pin(12, 1'b1);
    got = 1'b0;
    repeat (6)
    begin
      @(posedge clk);
      #1;
      if (drive_reset === 1'b1)
        got = 1'b1;
    end
    chk("drive_reset", 32'(got), 32'h1);
    pin(11, 1'b0);
    pin(12, 1'b0);
    pin(7, 1'b1);
    st(EXT, 1'b1, 1'b1);
    w(RQ, 32'h1);
    st(PNL, 1'b0, 1'b1);
    pin(8, 1'b1);
    pin(10, 1'b1);
    pin(7, 1'b0);
    st(EXT, 1'b0, 1'b0);
    pin(7, 1'b1);
    st(EXT, 1'b1, 1'b1);
    w(RQ, 32'h1);
    st(EXT, 1'b1, 1'b1);
    pin(7, 1'b0);
    st(EXT, 1'b0, 1'b0);
    pin(7, 1'b1);
    pin(8, 1'b0);
    pin(10, 1'b0);
    st(EXT, 1'b1, 1'b1);
    // Inverted stop logic turns the high pin into an inactive interlock
    w(SL, 32'h2);
    st(EXT, 1'b0, 1'b0);
    pin(7, 1'b0);
    st(EXT, 1'b1, 1'b1);
    w(SL, 32'h0);
    pin(7, 1'b1);
    st(EXT, 1'b1, 1'b1);
    w(WS, 32'h1);
    w(SL, 32'h1);
    r(SL, 32'h0);
    chk("param_write_en", 32'(param_write_en), 32'h0);
    w(WS, 32'h0);
    w(8'h20, 32'h0C);
    st(EXT, 1'b1, 1'b0);
    pin(0, 1'b1);
    st(EXT, 1'b1, 1'b1);
    w(8'h20, 32'h0);
    w(RQ, 32'h1);
    st(PNL, 1'b0, 1'b1);
    w(MS, 32'h0);
    st(PNL, 1'b1, 1'b1);
    pin(7, 1'b0);
    st(PNL, 1'b0, 1'b1);
    w(MS, 32'h7);
    st(EXT, 1'b0, 1'b0);
    // Status: external, no stop, interlock off, writes barred, forced flag set
    r(oms_pkg::A_STATUS, 32'h1 << oms_pkg::ST_FORCED_BIT);
    wrap_up;
  end
endmodule
`default_nettype wire
